/* File: hdl/sac_pkg.sv */
// Constants, register map and state types for the converter control block.
// Assumes a 50 MHz APB clock and a device cycle time given as a time constant.
package sac_pkg;
  // ==========================================================
  // Bus and register map (printed offsets are word indices)
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_CTRL = 16'hfe58;
  localparam logic [15:0] IDX_MODE = 16'hfe59;
  localparam logic [15:0] IDX_LOW = 16'hfe5a;
  localparam logic [15:0] IDX_HIGH = 16'hfe5b;
  localparam logic [ADDR_W-1:0] ADR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_MODE = {IDX_MODE, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_LOW = {IDX_LOW, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_HIGH = {IDX_HIGH, 2'b00};
  localparam logic [7:0] REG_RESET = 8'h00;
  // ==========================================================
  // Field positions
  localparam int CTRL_CH_LSB = 4;
  localparam int CTRL_GO = 2;
  localparam int CTRL_DONE = 1;
  localparam int CTRL_IE = 0;
  localparam int MODE_RES = 6;
  localparam int LOW_NIB_LSB = 4;
  localparam int LOW_DIV = 0;
  localparam logic [15:0] IRQ_VECTOR = 16'h0043;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int TCYC_NS = 60;
  localparam int THIRD_CLKS = (TCYC_NS + 3 * CLK_NS - 1) / (3 * CLK_NS);
  localparam int BASE12 = 52;
  localparam int BASE8 = 32;
  localparam int SETTLE = 2;
  localparam int STEP_UNITS = 4;
  // ==========================================================
  // State
  typedef enum logic {ST_IDLE, ST_CONV} sac_state_e;
  typedef struct packed {
    sac_state_e st;
    logic [3:0] ch;
    logic go;
    logic done;
    logic ie;
    logic res8;
    logic [1:0] div_lo;
    logic [3:0] low_nib;
    logic div_hi;
    logic [7:0] high;
    logic need_dbl;
    logic [11:0] sar;
    logic [3:0] bit_idx;
    logic sdone;
    logic [14:0] elap;
    logic [10:0] stepc;
    logic [7:0] pres;
    logic run_res8;
    logic [2:0] run_div;
    logic run_dbl;
    logic ladder_en;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sac_regs_s;
endpackage

/* File: hdl/sac_top.sv */
// SAR converter control: registers, sequencing, timing, result write-back.
// Assumes an APB master on pclk and an analog comparator sampled each step.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
// Contract
// - Channel field bits 7..4 selects input 0-4
// - Writing start bit one begins conversion
// - Start bit self-clears at conversion end
// - Clearing start mid-conversion aborts, results invalid
// - End flag bit 1 set on completion
// - End flag stays until software clears it
// - Interrupt when enable and end flag set
// - Mode bit 6 picks 12 or 8 bits
// - 8-bit result only to high register
// - 12-bit result: high byte, low nibble
// - Divider code from low bit0, mode bits1:0
// - 12-bit time (52/ratio+2) thirds Tcyc
// - 8-bit time (32/ratio+2) thirds Tcyc
// - First 12-bit conversion after reset/switch doubled
// - Reference ladder on only during conversion
// - Reset clears start and halts conversion
// - End flag and start clear together
module sac_top (
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [sac_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic comp_in, // Comparator: input at or above trial level
  output logic [3:0] input_channel_mux, // Analog input select
  output logic [11:0] ladder_tap_mux, // Trial code to ladder
  output logic ladder_enable, // Reference generator on
  output logic conv_irq // Interrupt request
);
  sac_pkg::sac_regs_s q, n;
  logic acc, wr, fin, tick, step_end;
  logic [1:0] sel;
  logic hit;
  logic [2:0] dsel;

  // ==========================================================
  // Helpers
  function automatic logic [2:0] dec(input logic [sac_pkg::ADDR_W-1:0] a);
    dec = 3'h0;
    if (a == sac_pkg::ADR_CTRL) dec = 3'h4;
    if (a == sac_pkg::ADR_MODE) dec = 3'h5;
    if (a == sac_pkg::ADR_LOW) dec = 3'h6;
    if (a == sac_pkg::ADR_HIGH) dec = 3'h7;
  endfunction

  // Length of a conversion in thirds of Tcyc
  function automatic logic [14:0] dur(input logic r8, input logic [2:0] dv, input logic db);
    logic [14:0] d;
    d = (r8 ? 15'(sac_pkg::BASE8) : 15'(sac_pkg::BASE12)) << dv;
    d = d + 15'(sac_pkg::SETTLE);
    dur = db ? (d << 1) : d;
  endfunction

  function automatic logic [10:0] steplen(input logic [2:0] dv, input logic db);
    steplen = (11'(sac_pkg::STEP_UNITS) << dv) << db;
  endfunction

  assign acc = psel && penable && q.pready;
  assign wr = acc && pwrite;
  assign dsel = dec(paddr);
  assign sel = dsel[1:0];
  assign hit = dsel[2];
  assign tick = (q.pres == 8'(sac_pkg::THIRD_CLKS - 1));
  assign step_end = tick && (q.stepc == steplen(q.run_div, q.run_dbl) - 11'h001);
  assign fin = (q.st == sac_pkg::ST_CONV) && tick
    && (q.elap == dur(q.run_res8, q.run_div, q.run_dbl) - 15'h0001);

  // ==========================================================
  // Next state
  always_comb begin
    n = q;
    n.pready = 1'b1;
    // Conversion progress
    if (q.st == sac_pkg::ST_CONV) begin
      n.pres = tick ? 8'h00 : q.pres + 8'h01;
      if (tick) begin
        n.elap = q.elap + 15'h0001;
        n.stepc = step_end ? 11'h000 : q.stepc + 11'h001;
      end
      if (step_end && !q.sdone) begin
        if (!comp_in) n.sar[q.bit_idx] = 1'b0;
        if (q.bit_idx == (q.run_res8 ? 4'h4 : 4'h0)) n.sdone = 1'b1;
        else begin
          n.bit_idx = q.bit_idx - 4'h1;
          n.sar[q.bit_idx - 4'h1] = 1'b1;
        end
      end
      if (fin) begin
        n.high = n.sar[11:4];
        if (!q.run_res8) n.low_nib = n.sar[3:0];
        n.st = sac_pkg::ST_IDLE;
        n.ladder_en = 1'b0;
      end
    end
    // Register reads are captured in the setup cycle
    if (psel && !penable) begin
      n.pslverr = !hit;
      case (sel)
        2'd0: n.prdata = {24'h0, q.ch, 1'b0, q.go, q.done, q.ie};
        2'd1: n.prdata = {24'h0, 1'b0, q.res8, 4'h0, q.div_lo};
        2'd2: n.prdata = {24'h0, q.low_nib, 3'h0, q.div_hi};
        2'd3: n.prdata = {24'h0, q.high};
        default: n.prdata = 32'h0;
      endcase
      if (!hit) n.prdata = 32'h0;
    end
    if (wr && hit) begin
      case (sel)
        2'd0: begin
          n.ch = pwdata[sac_pkg::CTRL_CH_LSB +: 4];
          n.ie = pwdata[sac_pkg::CTRL_IE];
          n.done = pwdata[sac_pkg::CTRL_DONE];
          if (!pwdata[sac_pkg::CTRL_GO] && q.st == sac_pkg::ST_CONV && !fin) begin
            n.st = sac_pkg::ST_IDLE;
            n.go = 1'b0;
            n.ladder_en = 1'b0;
          end
          if (pwdata[sac_pkg::CTRL_GO] && q.st == sac_pkg::ST_IDLE) begin
            n.st = sac_pkg::ST_CONV;
            n.go = 1'b1;
            n.ladder_en = 1'b1;
            n.run_res8 = q.res8;
            n.run_div = {q.div_hi, q.div_lo};
            n.run_dbl = q.need_dbl && !q.res8;
            if (!q.res8) n.need_dbl = 1'b0;
            n.sar = 12'h800;
            n.bit_idx = 4'hb;
            n.sdone = 1'b0;
            n.elap = 15'h0000;
            n.stepc = 11'h000;
            n.pres = 8'h00;
          end
        end
        2'd1: begin
          n.res8 = pwdata[sac_pkg::MODE_RES];
          n.div_lo = pwdata[1:0];
          if (q.res8 && !pwdata[sac_pkg::MODE_RES]) n.need_dbl = 1'b1;
        end
        2'd2: begin
          n.low_nib = pwdata[sac_pkg::LOW_NIB_LSB +: 4];
          n.div_hi = pwdata[sac_pkg::LOW_DIV];
        end
        2'd3: n.high = pwdata[7:0];
        default: n.high = q.high;
      endcase
    end
    // Completion wins over a same-cycle software clear
    if (fin) begin
      n.done = 1'b1;
      n.go = 1'b0;
    end
    n.irq = n.ie && n.done;
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.need_dbl <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign input_channel_mux = q.ch;
  assign ladder_tap_mux = q.sar;
  assign ladder_enable = q.ladder_en;
  assign conv_irq = q.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Reference timing
  function automatic logic [15:0] ref_len(input logic r8, input logic [2:0] dv, input logic db);
    logic [15:0] base;
    logic [15:0] mult;
    base = r8 ? 16'(sac_pkg::BASE8) : 16'(sac_pkg::BASE12);
    case (dv)
      3'd0: mult = 16'h0001;
      3'd1: mult = 16'h0002;
      3'd2: mult = 16'h0004;
      3'd3: mult = 16'h0008;
      3'd4: mult = 16'h0010;
      3'd5: mult = 16'h0020;
      3'd6: mult = 16'h0040;
      default: mult = 16'h0080;
    endcase
    ref_len = (base * mult + 16'(sac_pkg::SETTLE)) * (db ? 16'h0002 : 16'h0001)
      * 16'(sac_pkg::THIRD_CLKS);
  endfunction

  logic [15:0] run_cnt;
  logic [15:0] exp_cnt;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_low;
  assign wr_ctrl = wr && hit && sel == 2'd0;
  assign wr_mode = wr && hit && sel == 2'd1;
  assign wr_low = wr && hit && sel == 2'd2;
  assign exp_cnt = ref_len(q.run_res8, q.run_div, q.run_dbl);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_cnt <= 16'h0000;
    else if (q.st == sac_pkg::ST_IDLE) run_cnt <= 16'h0000;
    else run_cnt <= run_cnt + 16'h0001;
  end

  sequence s_start;
    wr_ctrl && pwdata[sac_pkg::CTRL_GO] && q.st == sac_pkg::ST_IDLE;
  endsequence
  sequence s_abort;
    wr_ctrl && !pwdata[sac_pkg::CTRL_GO] && q.st == sac_pkg::ST_CONV && !fin;
  endsequence
  sequence s_finish;
    fin;
  endsequence
  sequence s_finish_quiet;
    fin && !(wr && hit);
  endsequence
  sequence s_mode_to12;
    wr_mode && q.res8 && !pwdata[sac_pkg::MODE_RES];
  endsequence

  AST_START: assert property (s_start |=> q.st == sac_pkg::ST_CONV && q.go && ladder_enable)
    else $error("start write did not begin conversion");
  AST_ABORT: assert property (s_abort |=> !q.go && !ladder_enable ##1 !q.go)
    else $error("abort did not stop conversion");
  AST_FINISH: assert property (s_finish |=> q.done && !q.go && !ladder_enable)
    else $error("finish did not set flag and clear start together");
  AST_DUR: assert property (s_finish |-> run_cnt == exp_cnt - 16'h0001)
    else $error("conversion length wrong");
  AST_STICKY: assert property (q.done && !wr_ctrl |=> q.done)
    else $error("end flag dropped without a write");
  AST_IRQ: assert property (q.ie && q.done |-> conv_irq)
    else $error("interrupt missing");
  AST_LADDER: assert property (ladder_enable == (q.st == sac_pkg::ST_CONV))
    else $error("ladder enable out of step with conversion");
  AST_LOW8: assert property (s_finish and q.run_res8 |=> $stable(q.low_nib))
    else $error("low result changed in 8-bit mode");
  AST_GO_ONLY_RUN: assert property (q.go |-> q.st == sac_pkg::ST_CONV)
    else $error("start bit set while idle");

  // ==========================================================
  // Register write checks
  AST_CH_SEL: assert property (wr_ctrl |=>
    input_channel_mux == $past(pwdata[sac_pkg::CTRL_CH_LSB +: 4]))
    else $error("channel select not taken from the write");
  AST_IE_WR: assert property (wr_ctrl |=> q.ie == $past(pwdata[sac_pkg::CTRL_IE]))
    else $error("interrupt enable not taken from the write");
  AST_RES_SEL: assert property (wr_mode |=>
    q.res8 == $past(pwdata[sac_pkg::MODE_RES]))
    else $error("resolution select not taken from the write");
  AST_DIV_HI: assert property (wr_low |=>
    q.div_hi == $past(pwdata[sac_pkg::LOW_DIV]))
    else $error("divider top bit not taken from the write");
  AST_DONE_CLR: assert property (wr_ctrl && !pwdata[sac_pkg::CTRL_DONE] && !fin |=>
    !q.done)
    else $error("end flag not cleared by software");
  AST_DONE_SRC: assert property (!q.done && !fin && !wr_ctrl |=> !q.done)
    else $error("end flag set without a finish or a write");
  AST_IRQ_OFF: assert property (!(q.ie && q.done) |-> !conv_irq)
    else $error("interrupt raised without enable and flag");

  // ==========================================================
  // Conversion checks
  AST_GO_CAUSE: assert property ($rose(q.go) |->
    $past(wr_ctrl && pwdata[sac_pkg::CTRL_GO]))
    else $error("start bit rose without a start write");
  AST_GO_HOLD: assert property (q.go && !fin |=>
    q.go || $past(wr_ctrl && !pwdata[sac_pkg::CTRL_GO]))
    else $error("start bit dropped before finish");
  AST_RUN_RES: assert property (s_start |=> q.run_res8 == $past(q.res8))
    else $error("resolution not latched at start");
  AST_DIV_SEL: assert property (s_start |=> q.run_div == $past({q.div_hi, q.div_lo}))
    else $error("divider code not latched at start");
  AST_NO_OVERRUN: assert property (q.st == sac_pkg::ST_CONV |-> run_cnt < exp_cnt)
    else $error("conversion ran past its length");
  AST_DBL_12ONLY: assert property (q.st == sac_pkg::ST_CONV && q.run_res8 |->
    !q.run_dbl)
    else $error("8-bit conversion given doubled length");
  AST_DBL_ARM: assert property (s_mode_to12 |=> q.need_dbl)
    else $error("switch to 12-bit did not arm the doubled run");

  // ==========================================================
  // Successive-approximation and result checks
  AST_TRIAL_FIRST: assert property (s_start |=> ladder_tap_mux == 12'h800)
    else $error("first trial code not at mid-scale");
  AST_TRIAL_STEP: assert property (q.st == sac_pkg::ST_CONV && !step_end |=>
    $stable(ladder_tap_mux))
    else $error("trial code moved between steps");
  AST_STEPS_DONE: assert property (s_finish |-> q.sdone)
    else $error("conversion ended before its last step");
  AST_HIGH8: assert property (s_finish_quiet and q.run_res8 |=>
    q.high == q.sar[11:4])
    else $error("8-bit result not in high register");
  AST_RES12: assert property (s_finish_quiet and !q.run_res8 |=>
    {q.high, q.low_nib} == q.sar)
    else $error("12-bit result not split over both registers");
  AST_ABORT_KEEP: assert property (s_abort |=> $stable(q.high) && $stable(q.low_nib))
    else $error("abort changed the result registers");
endmodule

/* File: bench/sac_comp_model.sv */
// Analog side model: five fixed input levels and the comparator.
// Assumes the ladder code is the trial level and is valid while the ladder is on.
`timescale 1ns/100ps
module sac_comp_model #(
  parameter logic [59:0] VIN = 60'h0 // Input levels, channel i at [12*i +: 12]
) (
  input wire logic [3:0] input_channel_mux, // Selected input
  input wire logic [11:0] ladder_tap_mux, // Trial level
  input wire logic ladder_enable, // Reference generator on
  output logic comp_in // Input at or above trial level
);
  // ==========================================================
  // Input mux and comparator
  logic [11:0] level;
  always_comb begin
    level = (input_channel_mux < 4'h5) ? VIN[12*input_channel_mux +: 12] : 12'h000;
    comp_in = ladder_enable & (level >= ladder_tap_mux);
  end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the converter control block.
// Assumes the comparator model drives the compare input.
`timescale 1ns/100ps
module testbench;
  // ==========================================================
  // Signals
  localparam logic [17:0] AC = sac_pkg::ADR_CTRL;
  localparam logic [17:0] AM = sac_pkg::ADR_MODE;
  localparam logic [17:0] AL = sac_pkg::ADR_LOW;
  localparam logic [17:0] AH = sac_pkg::ADR_HIGH;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, comp_in, ladder_enable, conv_irq, rerr;
  logic [3:0] input_channel_mux;
  logic [11:0] ladder_tap_mux;
  logic [7:0] rdat;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  always #10 pclk = ~pclk;
  sac_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_in(comp_in), .input_channel_mux(input_channel_mux),
    .ladder_tap_mux(ladder_tap_mux), .ladder_enable(ladder_enable), .conv_irq(conv_irq));
  sac_comp_model #(.VIN(60'h2e7_123_456_c3f_5a3)) u_comp (.input_channel_mux(input_channel_mux),
    .ladder_tap_mux(ladder_tap_mux), .ladder_enable(ladder_enable), .comp_in(comp_in));
  // ==========================================================
  // Bus and checking tasks
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [17:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    apb(a, 1'h1, d);
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] e);
    apb(a, 1'h0, 8'h00);
    check_eq(32'(rdat), 32'(e));
  endtask
  task automatic irq_is(input logic e);
    @(posedge pclk);
    check_eq(32'(conv_irq), 32'(e));
  endtask
  // Start, time the ladder-on window, then check flags and high byte
  task automatic conv(input logic [7:0] ctl, input int len, input logic [7:0] ectl, ehi);
    int n;
    n = 0;
    wr(AC, ctl);
    do begin
      @(posedge pclk);
      n++;
    end while (ladder_enable === 1'h1 && n < 9000);
    check_eq(32'(n), 32'(len + 1));
    check_eq(32'(input_channel_mux), 32'(ctl[7:4]));
    rd(AC, ectl);
    check_eq(32'(conv_irq), 32'(ectl[1] & ectl[0]));
    rd(AH, ehi);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(AC, 8'h00);
    rd(AM, 8'h00);
    rd(AL, 8'h00);
    rd(AH, 8'h00);
    rd(18'h00000, 8'h00);
    check_eq(32'(rerr), 32'h1);
  endtask
  task automatic t_first;
    conv(8'h45, 108, 8'h43, 8'h2e);
    rd(AL, 8'h70);
    check_eq(32'(ladder_tap_mux), 32'h000002e7);
    wr(AC, 8'h41);
    irq_is(1'h0);
  endtask
  task automatic t_div;
    wr(AM, 8'h01);
    conv(8'h05, 106, 8'h03, 8'h5a);
    rd(AL, 8'h30);
    repeat (20) @(posedge pclk);
    rd(AC, 8'h03);
    wr(AC, 8'h01);
  endtask
  task automatic t_eight;
    wr(AL, 8'ha1);
    rd(AL, 8'ha1);
    wr(AM, 8'h43);
    conv(8'h15, 4098, 8'h13, 8'hc3);
    rd(AL, 8'ha1);
    check_eq(32'(ladder_tap_mux), 32'h00000c30);
    wr(AC, 8'h11);
  endtask
  task automatic t_switch;
    wr(AL, 8'h00);
    wr(AM, 8'h00);
    conv(8'h05, 108, 8'h03, 8'h5a);
    rd(AL, 8'h30);
    wr(AC, 8'h01);
  endtask
  task automatic t_abort;
    wr(AC, 8'h15);
    repeat (10) @(posedge pclk);
    wr(AC, 8'h10);
    repeat (2) @(posedge pclk);
    check_eq(32'(ladder_enable), 32'h0);
    rd(AC, 8'h10);
    rd(AH, 8'h5a);
    rd(AL, 8'h30);
  endtask
  task automatic t_mask;
    conv(8'h44, 54, 8'h42, 8'h2e);
    wr(AC, 8'h43);
    irq_is(1'h1);
    wr(AC, 8'h40);
    irq_is(1'h0);
  endtask
  task automatic t_rst_mid;
    wr(AC, 8'h05);
    repeat (5) @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    check_eq(32'(ladder_enable), 32'h0);
    rd(AC, 8'h00);
    conv(8'h05, 108, 8'h03, 8'h5a);
  endtask
  // ==========================================================
  // Sequence, timeout and verdict
  task automatic report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_first();
    t_div();
    t_eight();
    t_switch();
    t_abort();
    t_mask();
    t_rst_mid();
    report_and_stop();
  end
endmodule
